/* pkg/drt_defines.svh */
// Constants of the diagnostic record and microsecond ticker block
// Overview of operation
// - A 32-bit counter advances once per microsecond as timestamp source.
// - Reset clears the counter to zero; counting starts at once.
// - At all ones the counter rolls to zero and keeps counting.
// - The 16-bit interrupt timestamp is the counter's low two bytes.
// - Incoming diagnostic interrupts are raised only while the enable parameter is set; going ones are not gated.
// - A new fault raises an incoming interrupt and presents the record.
// - When the fault clears a going interrupt follows without controller action.
// - Channel events between incoming and going interrupts are discarded.
// - The fault LED is lit from first incoming to last going interrupt.
// - Summary byte: bits 0,1,2,3,4,7 carry faults; bits 5 and 6 zero.
// - Extended byte: bit 3 buffer overflow, 4 communication, 6 lost interrupt.
// - Class byte holds analog class 0101b plus channel-info bit 4: 15h.
// - Channel type byte reads 71h for analog input; bit 7 zero.
// - Diagnostic bits per channel byte reads 08h.
// - Channel count byte reads 02h.
// - Group error byte: bit 0 group 0, bit 1 group 1, others zero.
// - Channel byte: bits 0,4,5,6,7 carry faults; bits 3 to 1 zero.
// - The 4-byte timestamp captures the counter when the event is recorded.
// - A short record with only the first four bytes has its own number.
`ifndef DRT_DEFINES_SVH
`define DRT_DEFINES_SVH
`define DRT_CLK_MHZ        40
`define DRT_US_TICKS       (`DRT_CLK_MHZ)
`define DRT_CLASS_INFO     8'h15
`define DRT_CHAN_KIND      8'h71
`define DRT_BITS_PER_CH    8'h08
`define DRT_CH_COUNT       8'h02
`define DRT_SPARE          8'h00
`define DRT_REC_SHORT      8'h00
`define DRT_REC_FULL       8'h01
`define DRT_SHORT_LEN      5'h04
`define DRT_FULL_LEN       5'h14
`define DRT_SUM_MASK       8'h9F
`define DRT_EXT_MASK       8'h58
`define DRT_CH_MASK        8'hF1
`define DRT_SUM_CHAN_BIT   3
`define DRT_IDX_SUMMARY    5'h00
`define DRT_IDX_CLASS      5'h01
`define DRT_IDX_SPARE      5'h02
`define DRT_IDX_EXT        5'h03
`define DRT_IDX_KIND       5'h04
`define DRT_IDX_BITS       5'h05
`define DRT_IDX_COUNT      5'h06
`define DRT_IDX_GROUP      5'h07
`define DRT_IDX_CH0        5'h08
`define DRT_IDX_CH1        5'h09
`define DRT_IDX_TS0        5'h10
`define DRT_IDX_TS1        5'h11
`define DRT_IDX_TS2        5'h12
`define DRT_IDX_TS3        5'h13
`endif

/* pkg/drt_pkg.sv */
// Types of the diagnostic record and microsecond ticker block
package drt_pkg;
  typedef enum logic [1:0] {DRT_IDLE, DRT_ACTIVE} drt_state_e;
  typedef logic [7:0] drt_byte_t;
endpackage

/* rtl/drt_diag_record.sv */
// Diagnostic record, fault LED and microsecond ticker of a two-channel analog input module
`timescale 1ns/1ps
`default_nettype none
`include "drt_defines.svh"
module drt_diag_record
  import drt_pkg::*;
#(
  parameter int US_TICKS = `DRT_US_TICKS
) (
  // Clock and reset
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  // Parameter setting
  input  wire logic        diag_irq_enable_in,
  // Fault sources
  input  wire logic [7:0]  summary_faults_in,
  input  wire logic [7:0]  extended_faults_in,
  input  wire logic [7:0]  channel0_faults_in,
  input  wire logic [7:0]  channel1_faults_in,
  // Record read port
  input  wire logic        rec_read_in,
  input  wire logic [7:0]  record_set_number_in,
  input  wire logic [4:0]  object_index_in,
  output logic [7:0]       rec_data_out,
  output logic             rec_valid_out,
  // Interrupt and status
  output logic             diag_incoming_out,
  output logic             diag_going_out,
  output logic             module_fault_led_out,
  output logic [15:0]      irq_timestamp_low16_out,
  output logic [31:0]      us_counter_out
);

  // ************************************************************
  // Microsecond ticker
  // ************************************************************
  logic [5:0]  presc_ff;
  logic [31:0] us_ff;
  wire         us_tick = (presc_ff == 6'(US_TICKS - 1));

  // Wraps naturally at all ones, so no stop condition exists
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      presc_ff <= 6'h00;
      us_ff    <= 32'h0000_0000;
    end else begin
      presc_ff <= us_tick ? 6'h00 : presc_ff + 6'h01;
      if (us_tick) begin
        us_ff <= us_ff + 32'h0000_0001;
      end
    end
  end

  assign us_counter_out          = us_ff;
  assign irq_timestamp_low16_out = us_ff[15:0];

  // ************************************************************
  // Live fault view
  // ************************************************************
  wire [7:0] ch0_live = channel0_faults_in & `DRT_CH_MASK;
  wire [7:0] ch1_live = channel1_faults_in & `DRT_CH_MASK;
  wire [7:0] grp_live = {6'h00, |ch1_live, |ch0_live};
  wire [7:0] sum_base = summary_faults_in & `DRT_SUM_MASK & ~(8'h01 << `DRT_SUM_CHAN_BIT);
  wire [7:0] sum_live = sum_base | ({7'h00, |grp_live} << `DRT_SUM_CHAN_BIT);
  wire [7:0] ext_live = extended_faults_in & `DRT_EXT_MASK;
  wire       any_live = |{sum_live, ext_live, ch0_live, ch1_live};

  // ************************************************************
  // Incoming / going sequencer
  // ************************************************************
  drt_state_e state_ff;
  drt_state_e nxt_state;
  logic [7:0]  sum_ff;
  logic [7:0]  ext_ff;
  logic [7:0]  ch0_ff;
  logic [7:0]  ch1_ff;
  logic [31:0] ts_ff;
  logic        inc_ff;
  logic        go_ff;
  wire         start = any_live & diag_irq_enable_in;
  wire         finish = ~any_live;

  // Next state; once active, new events are ignored until all faults clear
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      DRT_IDLE:   if (start) nxt_state = DRT_ACTIVE;
      DRT_ACTIVE: if (finish) nxt_state = DRT_IDLE;
      default:    nxt_state = DRT_IDLE;
    endcase
  end

  // Record is frozen at the incoming event, so later events are lost
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_ff <= DRT_IDLE;
      sum_ff   <= 8'h00;
      ext_ff   <= 8'h00;
      ch0_ff   <= 8'h00;
      ch1_ff   <= 8'h00;
      ts_ff    <= 32'h0000_0000;
      inc_ff   <= 1'b0;
      go_ff    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      inc_ff   <= (state_ff == DRT_IDLE) && (nxt_state == DRT_ACTIVE);
      go_ff    <= (state_ff == DRT_ACTIVE) && (nxt_state == DRT_IDLE);
      if ((state_ff == DRT_IDLE) && start) begin
        sum_ff <= sum_live;
        ext_ff <= ext_live;
        ch0_ff <= ch0_live;
        ch1_ff <= ch1_live;
        ts_ff  <= us_ff;
      end else if (go_ff) begin
        sum_ff <= 8'h00;
        ext_ff <= 8'h00;
        ch0_ff <= 8'h00;
        ch1_ff <= 8'h00;
      end
    end
  end

  assign diag_incoming_out    = inc_ff;
  assign diag_going_out       = go_ff;
  assign module_fault_led_out = (state_ff == DRT_ACTIVE);

  // ************************************************************
  // Record read port
  // ************************************************************
  wire [7:0] grp_rec = {6'h00, |ch1_ff, |ch0_ff};
  wire       is_short = (record_set_number_in == `DRT_REC_SHORT);
  wire       is_full  = (record_set_number_in == `DRT_REC_FULL);
  wire [4:0] rec_len  = is_short ? `DRT_SHORT_LEN : `DRT_FULL_LEN;
  wire       in_range = (is_short | is_full) && (object_index_in < rec_len);
  logic [7:0] sel_byte;
  logic [7:0] data_ff;
  logic       valid_ff;

  // Byte select; spare bytes read zero
  always_comb begin
    sel_byte = 8'h00;
    case (object_index_in)
      `DRT_IDX_SUMMARY: sel_byte = sum_ff;
      `DRT_IDX_CLASS:   sel_byte = `DRT_CLASS_INFO;
      `DRT_IDX_SPARE:   sel_byte = `DRT_SPARE;
      `DRT_IDX_EXT:     sel_byte = ext_ff;
      `DRT_IDX_KIND:    sel_byte = `DRT_CHAN_KIND;
      `DRT_IDX_BITS:    sel_byte = `DRT_BITS_PER_CH;
      `DRT_IDX_COUNT:   sel_byte = `DRT_CH_COUNT;
      `DRT_IDX_GROUP:   sel_byte = grp_rec;
      `DRT_IDX_CH0:     sel_byte = ch0_ff;
      `DRT_IDX_CH1:     sel_byte = ch1_ff;
      `DRT_IDX_TS0:     sel_byte = ts_ff[7:0];
      `DRT_IDX_TS1:     sel_byte = ts_ff[15:8];
      `DRT_IDX_TS2:     sel_byte = ts_ff[23:16];
      `DRT_IDX_TS3:     sel_byte = ts_ff[31:24];
      default:          sel_byte = 8'h00;
    endcase
  end

  // Registered answer one cycle after the read strobe
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      data_ff  <= 8'h00;
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= rec_read_in;
      if (rec_read_in) begin
        data_ff <= in_range ? sel_byte : 8'h00;
      end
    end
  end

  assign rec_data_out  = data_ff;
  assign rec_valid_out = valid_ff;

endmodule
`default_nettype wire

/* bench/drt_diag_record_checker.sv */
// Assertion checker of the diagnostic record block
`timescale 1ns/1ps
`default_nettype none
module drt_diag_record_checker (
  // Watched ports, grouped by width to keep the file short
  input wire logic        clk_in, rst_in, diag_irq_enable_in, rec_read_in, rec_valid_out,
  input wire logic        diag_incoming_out, diag_going_out, module_fault_led_out,
  input wire logic [7:0]  summary_faults_in, extended_faults_in, channel0_faults_in,
  input wire logic [7:0]  channel1_faults_in, record_set_number_in, rec_data_out,
  input wire logic [4:0]  object_index_in,
  input wire logic [15:0] irq_timestamp_low16_out,
  input wire logic [31:0] us_counter_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // Summary bit 3 is left out: it is derived from the channels, not a cause
  wire logic any_fault = |{summary_faults_in & 8'h97, extended_faults_in & 8'h58,
                           channel0_faults_in & 8'hF1, channel1_faults_in & 8'hF1};
  chk_read_answer: assert property (rec_read_in |=> rec_valid_out)
    else $error("read not answered");
  chk_class_byte: assert property (rec_read_in && object_index_in == 5'h01 && record_set_number_in <= 8'h01 |=> rec_data_out == 8'h15)
    else $error("class byte wrong");
  chk_short_len: assert property (rec_read_in && record_set_number_in == 8'h00 && object_index_in >= 5'h04 |=> rec_data_out == 8'h00)
    else $error("short record too long");
  chk_us_step: assert property (!$stable(us_counter_out) |-> us_counter_out == $past(us_counter_out) + 32'h1)
    else $error("counter step wrong");
  chk_ts_low: assert property ($stable(us_counter_out) |-> irq_timestamp_low16_out == us_counter_out[15:0])
    else $error("timestamp low half wrong");
  chk_irq_off: assert property (!diag_irq_enable_in && !module_fault_led_out |=> !diag_incoming_out)
    else $error("interrupt while disabled");
  chk_incoming_cause: assert property (diag_irq_enable_in && !module_fault_led_out && any_fault |=> diag_incoming_out && module_fault_led_out)
    else $error("incoming missing");
  chk_going_auto: assert property (module_fault_led_out && !any_fault |=> diag_going_out && !module_fault_led_out)
    else $error("going missing");
  chk_no_repeat: assert property (module_fault_led_out |=> !diag_incoming_out)
    else $error("second incoming");
  chk_led_span: assert property ($rose(module_fault_led_out) |-> diag_incoming_out)
    else $error("led without incoming");
  cover property (diag_incoming_out);
  cover property (diag_going_out);
  cover property (rec_read_in && record_set_number_in == 8'h00);
endmodule
bind drt_diag_record drt_diag_record_checker u_chk (.*);
`default_nettype wire

/* bench/drt_host_model.sv */
// Host-side reader of the diagnostic record
`timescale 1ns/1ps
`default_nettype none
module drt_host_model (
  // Bus clock
  input  wire logic       clk_in,
  // Record request and parameter setting
  output logic            rd_out,
  output logic [7:0]      num_out,
  output logic [4:0]      idx_out,
  output logic            en_out
);
  // Idle bus and interrupts off until the controller parameterises
  initial begin
    rd_out = 1'b0;
    num_out = 8'h00;
    idx_out = 5'h00;
    en_out = 1'b0;
  end
  // One-cycle strobe; record number picks the short or full record
  task rd(input logic [7:0] n, input logic [4:0] i);
    @(posedge clk_in);
    rd_out <= 1'b1;
    num_out <= n;
    idx_out <= i;
    @(posedge clk_in);
    rd_out <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* bench/diag_record_and_us_ticker_tb_top.sv */
// Self-checking bench of the diagnostic record block
`timescale 1ns/1ps
`default_nettype none
module diag_record_and_us_ticker_tb_top;
  import drt_pkg::*;
  logic        clk_in = 1'b0, rst_in = 1'b1, rec_read_in, diag_irq_enable_in, rec_valid_out;
  logic        diag_incoming_out, diag_going_out, module_fault_led_out;
  logic [7:0]  record_set_number_in, summary_faults_in, extended_faults_in, rec_data_out;
  logic [7:0]  channel0_faults_in, channel1_faults_in;
  logic [4:0]  object_index_in;
  logic [15:0] irq_timestamp_low16_out;
  logic [31:0] us_counter_out;
  int          err_count = 0, samples_checked = 0;
  drt_byte_t   exp_q[$];
  drt_byte_t   tbl[10] = '{8'h00, 8'h15, 8'h00, 8'h00, 8'h71, 8'h08, 8'h02, 8'h00, 8'h00, 8'h00};
  always #12.5 clk_in = ~clk_in;
  drt_host_model host (.clk_in(clk_in), .rd_out(rec_read_in), .num_out(record_set_number_in),
                       .idx_out(object_index_in), .en_out(diag_irq_enable_in));
  // Short tick keeps the run brief
  drt_diag_record #(.US_TICKS(4)) DUT (.*);
  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("unexpected %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // Note the expectation first, so the monitor never runs ahead of it
  task automatic rdx(input logic [7:0] n, input logic [4:0] i, input drt_byte_t e);
    exp_q.push_back(e);
    host.rd(n, i);
  endtask
  task automatic wt(input bit going);
    int k;
    for (k = 0; k < 300; k++) begin
      @(posedge clk_in);
      if ((going ? diag_going_out : diag_incoming_out) === 1'b1) break;
    end
    if (k == 300) begin
      check("irq wait", 0, 1);
      close_out();
    end
  endtask
  // Each answered read takes the oldest noted value
  always @(posedge clk_in)
    if (rec_valid_out === 1'b1 && exp_q.size() > 0)
      check("record byte", rec_data_out, exp_q.pop_front());
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    drt_byte_t s, x, c;
    {summary_faults_in, extended_faults_in, channel0_faults_in, channel1_faults_in} = '0;
    void'($urandom(32'hc704));
    repeat (16) @(posedge clk_in);
    rst_in <= 1'b0;
    check("counter", us_counter_out, 0);
    for (int i = 0; i < 16; i++) rdx(8'h01, i[4:0], i < 10 ? tbl[i] : 8'h00);
    for (int i = 0; i < 8; i++) rdx(8'h00, i[4:0], i < 4 ? tbl[i] : 8'h00);
    $display("test constants done");
    s = $urandom();
    x = $urandom();
    c = $urandom() | 8'h10;
    summary_faults_in <= s;
    extended_faults_in <= x;
    channel0_faults_in <= c;
    repeat (40) @(posedge clk_in);
    check("led", module_fault_led_out, 0);
    host.en_out <= 1'b1;
    wt(0);
    channel1_faults_in <= 8'h40;
    rdx(8'h01, 5'h00, (s & 8'h97) | 8'h08);
    rdx(8'h01, 5'h03, x & 8'h58);
    rdx(8'h01, 5'h07, 8'h01);
    rdx(8'h01, 5'h08, c & 8'hF1);
    rdx(8'h01, 5'h09, 8'h00);
    check("led", module_fault_led_out, 1);
    $display("test incoming done");
    {summary_faults_in, extended_faults_in, channel0_faults_in, channel1_faults_in} <= '0;
    wt(1);
    repeat (2) @(posedge clk_in);
    check("led", module_fault_led_out, 0);
    rdx(8'h01, 5'h08, 8'h00);
    repeat (4) @(posedge clk_in);
    $display("test going done");
    close_out();
  end
endmodule
`default_nettype wire
